// ==== rtl/dnl_consts.svh ====
// Constants for the numeric oscillator serial loader
`ifndef DNL_CONSTS_SVH
`define DNL_CONSTS_SVH
`define DNL_ACC_W 32
`define DNL_PHASE_W 12
`define DNL_AMP_W 10
`define DNL_WORD_W 16
`define DNL_BITCNT_W 5
`define DNL_BITS_PER_WORD 5'h10
`define DNL_CMD_HI 15
`define DNL_CMD_LO 12
`define DNL_ADDR_HI 11
`define DNL_ADDR_LO 8
`define DNL_DATA_HI 7
`define DNL_ADDR_KIND_BIT 3
`define DNL_ADDR_FSEL_BIT 2
`define DNL_ADDR_PSEL_HI 2
`define DNL_ADDR_PSEL_LO 1
`define DNL_CTL_FREQ_BIT 11
`define DNL_CTL_PHI_BIT 10
`define DNL_CTL_PLO_BIT 9
`define DNL_CTL_SYNC_BIT 12
`define DNL_CTL_SRC_BIT 13
`define DNL_CTL_KIND_BIT 14
`define DNL_AMP_MID 10'h200
`define DNL_AMP_HALF 10'h1ff
`endif

// ==== rtl/dnl_pkg.sv ====
// Types for the numeric oscillator serial loader
`default_nettype none
package dnl_pkg;
	typedef enum logic [3:0] {
		DNL_CMD_PHASE16 = 4'h0,
		DNL_CMD_PHASE8 = 4'h1,
		DNL_CMD_FREQ16 = 4'h2,
		DNL_CMD_FREQ8 = 4'h3,
		DNL_CMD_PSEL = 4'h4,
		DNL_CMD_FSEL = 4'h5,
		DNL_CMD_BOTHSEL = 4'h6,
		DNL_CMD_TEST = 4'h7
	} dnl_cmd_t;
	typedef enum logic [2:0] {
		DNL_ST_IDLE = 3'b001,
		DNL_ST_SHIFT = 3'b010,
		DNL_ST_DONE = 3'b100
	} dnl_state_t;
endpackage
`default_nettype wire

// ==== rtl/dnl_sine_rom.sv ====
// Sine lookup: 12-bit phase to 10-bit offset-binary amplitude
`default_nettype none
`include "dnl_consts.svh"
module dnl_sine_rom #(
	parameter int PW = `DNL_PHASE_W,
	parameter int AW = `DNL_AMP_W
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Phase in, amplitude out
	input wire logic [PW-1:0] i_phase,
	output logic [AW-1:0] o_amp
);
	// Table built at elaboration, one entry per phase step
	logic [AW-1:0] rom [0:(1<<PW)-1];
	generate
		for (genvar g = 0; g < (1 << PW); g++) begin : g_rom
			localparam real ANG = 6.283185307179586 * g / (1 << PW);
			localparam int TOP = (1 << AW) - 1;
			localparam real S = TOP / 2.0 * (1.0 + $sin(ANG));
			assign rom[g] = AW'($rtoi(S + 0.5) > TOP ? TOP : $rtoi(S + 0.5));
		end
	endgenerate
	// Registered read
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_amp <= `DNL_AMP_MID;
		end else begin
			o_amp <= rom[i_phase];
		end
	end
endmodule
`default_nettype wire

// ==== rtl/dnl_core.sv ====
// Numeric oscillator core with 16-bit framed serial register loader
`default_nettype none
`include "dnl_consts.svh"
// Functional notes
// - Phase accumulator is 32 bits; one wave cycle spans its full range.
// - Accumulator adds selected step every master clock, wrapping modulo 2^32.
// - Step comes from frequency word 0 or 1, chosen by pin or bit.
// - Changing frequency choice changes step only; accumulator is untouched.
// - One of four 12-bit phase offsets adds to accumulator top bits.
// - Top 12 bits of offset phase address the sine table.
// - Sine table gives 10-bit amplitude from a 12-bit address.
// - Each serial write carries exactly one 16-bit word.
// - Bits are captured on successive falling serial clock edges after frame low.
// - Serial clock may run freely or park high or low between words.
// - Two phase choice signals select offset register 0 to 3 in binary.
// - Frequency word n is the step when frequency choice equals n.
// - Word holds command in top nibble, address next, data in low byte.
// - Address top bit picks frequency or phase; lower bits pick register and byte.
// - Frequency word built as two separate 16-bit halves of two bytes each.
// - Commands 0..3 load phase/frequency 16 bits or just the holding byte.
// - Transfer follows the 16th falling edge; destination updates on master clock.
// - Source bit picks pins or register bits; clear input forces it to pins.
// - Choice pins sampled on master clock rising edge and applied from then.
module dnl_core
	import dnl_pkg::*;
#(
	parameter int ACC_W = `DNL_ACC_W,
	parameter int PH_W = `DNL_PHASE_W,
	parameter int AMP_W = `DNL_AMP_W
) (
	// Master clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Clear input, returns choice source to pins
	input wire logic i_clear_input,
	// Serial write port, sampled on master clock
	input wire logic i_sclk,
	input wire logic i_serial_data_in,
	input wire logic i_word_frame_n,
	// Choice pins
	input wire logic i_frequency_choice,
	input wire logic i_phase_choice_lo,
	input wire logic i_phase_choice_hi,
	// Amplitude to converter, phase tap and choice source bit
	output logic [AMP_W-1:0] o_amplitude,
	output logic [PH_W-1:0] o_phase,
	output logic o_choice_source_bit
);
	import dnl_pkg::*;

	// Serial input edge tracking
	logic sclk_q;
	logic frame_q;
	logic [`DNL_WORD_W-1:0] shift;
	logic [`DNL_BITCNT_W-1:0] bit_cnt;
	dnl_state_t state;
	dnl_state_t next_state;
	logic [`DNL_WORD_W-1:0] word;
	logic word_stb;

	wire sclk_fall = sclk_q & ~i_sclk;
	wire frame_active = ~i_word_frame_n;
	wire frame_start = frame_q & ~i_word_frame_n;

	// Framing state machine
	always_comb begin
		next_state = state;
		case (state)
			DNL_ST_IDLE: begin
				if (frame_active) begin
					next_state = DNL_ST_SHIFT;
				end
			end
			DNL_ST_SHIFT: begin
				if (!frame_active) begin
					next_state = DNL_ST_IDLE; // short frame dropped
				end else if (sclk_fall && bit_cnt == `DNL_BITS_PER_WORD - 5'h01) begin
					next_state = DNL_ST_DONE;
				end
			end
			DNL_ST_DONE: begin
				if (!frame_active) begin
					next_state = DNL_ST_IDLE;
				end
			end
			default: next_state = DNL_ST_IDLE;
		endcase
	end

	// Shift register, MSB first on falling serial edges
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sclk_q <= 1'b0;
			frame_q <= 1'b1;
			shift <= 16'h0000;
			bit_cnt <= 5'h00;
			state <= DNL_ST_IDLE;
			word <= 16'h0000;
			word_stb <= 1'b0;
		end else begin
			sclk_q <= i_sclk;
			frame_q <= i_word_frame_n;
			state <= next_state;
			word_stb <= 1'b0;
			if (frame_start) begin
				bit_cnt <= 5'h00;
			end
			if (state == DNL_ST_SHIFT && frame_active && sclk_fall) begin
				shift <= {shift[`DNL_WORD_W-2:0], i_serial_data_in};
				bit_cnt <= bit_cnt + 5'h01;
				if (next_state == DNL_ST_DONE) begin
					word <= {shift[`DNL_WORD_W-2:0], i_serial_data_in};
					word_stb <= 1'b1;
				end
			end else if (state == DNL_ST_IDLE) begin
				bit_cnt <= 5'h00;
			end
		end
	end

	// Word field decode
	wire [3:0] cmd = word[`DNL_CMD_HI:`DNL_CMD_LO];
	wire [3:0] addr = word[`DNL_ADDR_HI:`DNL_ADDR_LO];
	wire [7:0] data = word[`DNL_DATA_HI:0];
	wire is_ctl = word[`DNL_CMD_HI];

	// Holding byte and register storage
	logic [7:0] hold;
	logic [15:0] freq_half [0:3]; // index {fsel, msb half}
	logic [PH_W-1:0] phase_reg [0:3];
	logic src_bit;
	logic fbit;
	logic [1:0] pbits;
	logic sync_en;

	wire wr_phase16 = word_stb && !is_ctl && cmd == DNL_CMD_PHASE16;
	wire wr_freq16 = word_stb && !is_ctl && cmd == DNL_CMD_FREQ16;
	wire wr_hold = word_stb && !is_ctl &&
		(cmd == DNL_CMD_PHASE8 || cmd == DNL_CMD_FREQ8);
	wire [15:0] pair = {data, hold};
	wire [1:0] freq_idx = {addr[`DNL_ADDR_FSEL_BIT], addr[1]};
	wire [1:0] phase_idx = addr[`DNL_ADDR_PSEL_HI:`DNL_ADDR_PSEL_LO];

	// Holding byte load, both single- and double-byte commands refresh it
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hold <= 8'h00;
		end else if (wr_hold || wr_phase16 || wr_freq16) begin
			hold <= data;
		end
	end

	// Frequency halves: written when high byte of a half is addressed
	generate
		for (genvar h = 0; h < 4; h++) begin : g_freq
			always_ff @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					freq_half[h] <= 16'h0000;
				end else if (wr_freq16 && !addr[`DNL_ADDR_KIND_BIT] && addr[0] &&
					freq_idx == 2'(h)) begin
					freq_half[h] <= pair;
				end
			end
		end
		// Phase offsets: written when their high byte is addressed
		for (genvar p = 0; p < 4; p++) begin : g_phase
			always_ff @(posedge i_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					phase_reg[p] <= '0;
				end else if (wr_phase16 && addr[`DNL_ADDR_KIND_BIT] && addr[0] &&
					phase_idx == 2'(p)) begin
					phase_reg[p] <= pair[PH_W-1:0];
				end
			end
		end
	endgenerate

	// Control word: source, sync and choice bits
	wire ctl_sel = word_stb && is_ctl && !word[`DNL_CTL_KIND_BIT];
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			src_bit <= 1'b0;
			sync_en <= 1'b0;
			fbit <= 1'b0;
			pbits <= 2'b00;
		end else if (i_clear_input) begin
			src_bit <= 1'b0;
		end else if (ctl_sel) begin
			src_bit <= word[`DNL_CTL_SRC_BIT];
			sync_en <= word[`DNL_CTL_SYNC_BIT];
		end else if (word_stb && !is_ctl && word[`DNL_CTL_KIND_BIT]) begin
			if (cmd == DNL_CMD_FSEL || cmd == DNL_CMD_BOTHSEL) begin
				fbit <= word[`DNL_CTL_FREQ_BIT];
			end
			if (cmd == DNL_CMD_PSEL || cmd == DNL_CMD_BOTHSEL) begin
				pbits <= {word[`DNL_CTL_PHI_BIT], word[`DNL_CTL_PLO_BIT]};
			end
		end
	end

	// Pin sampling on master clock
	logic fpin;
	logic [1:0] ppin;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fpin <= 1'b0;
			ppin <= 2'b00;
		end else begin
			fpin <= i_frequency_choice;
			ppin <= {i_phase_choice_hi, i_phase_choice_lo};
		end
	end

	// Choice selection and step
	wire fsel = src_bit ? fbit : fpin;
	wire [1:0] psel = src_bit ? pbits : ppin;
	wire [ACC_W-1:0] step = {freq_half[{fsel, 1'b1}], freq_half[{fsel, 1'b0}]};

	// Accumulator, wraps naturally
	logic [ACC_W-1:0] acc;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc <= '0;
		end else begin
			acc <= acc + step;
		end
	end

	// Offset added to top bits then truncated
	wire [PH_W-1:0] next_phase = acc[ACC_W-1 -: PH_W] + phase_reg[psel];
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_phase <= '0;
			o_choice_source_bit <= 1'b0;
		end else begin
			o_phase <= next_phase;
			o_choice_source_bit <= src_bit;
		end
	end

	// Sine lookup
	dnl_sine_rom #(.PW(PH_W), .AW(AMP_W)) u_rom (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_phase(o_phase),
		.o_amp(o_amplitude)
	);

	// Checks
	property p_acc_wrap;
		@(posedge i_clk) disable iff (!i_resetn)
		acc == $past(acc) + $past(step);
	endproperty
	a_acc_wrap: assert property (p_acc_wrap) else $error("accumulator step wrong");

	property p_freq_load;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_freq16 && !addr[`DNL_ADDR_KIND_BIT] && addr[0]) |=>
			freq_half[$past(freq_idx)] == $past(pair);
	endproperty
	a_freq_load: assert property (p_freq_load) else $error("frequency half not loaded");

	property p_phase_load;
		@(posedge i_clk) disable iff (!i_resetn)
		(wr_phase16 && addr[`DNL_ADDR_KIND_BIT] && addr[0]) |=>
			phase_reg[$past(phase_idx)] == $past(pair[PH_W-1:0]);
	endproperty
	a_phase_load: assert property (p_phase_load) else $error("phase offset not loaded");

	property p_clear_src;
		@(posedge i_clk) disable iff (!i_resetn)
		i_clear_input |=> !src_bit ##1 !o_choice_source_bit;
	endproperty
	a_clear_src: assert property (p_clear_src) else $error("clear did not select pins");

	property p_pin_sample;
		@(posedge i_clk) disable iff (!i_resetn)
		1'b1 |=> fpin == $past(i_frequency_choice);
	endproperty
	a_pin_sample: assert property (p_pin_sample) else $error("pin not sampled");

	property p_word_count;
		@(posedge i_clk) disable iff (!i_resetn)
		word_stb |-> $past(bit_cnt) == `DNL_BITS_PER_WORD - 5'h01 && $past(sclk_fall);
	endproperty
	a_word_count: assert property (p_word_count) else $error("word not 16 edges");

	property p_msb_first;
		@(posedge i_clk) disable iff (!i_resetn)
		word_stb |-> word[0] == $past(i_serial_data_in);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("last bit not in lsb");

	property p_phase_out;
		@(posedge i_clk) disable iff (!i_resetn)
		1'b1 |=> o_phase == $past(acc[ACC_W-1 -: PH_W] + phase_reg[psel]);
	endproperty
	a_phase_out: assert property (p_phase_out) else $error("phase address wrong");

	property p_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		wr_hold |=> hold == $past(data) ##0 $stable(step);
	endproperty
	a_hold: assert property (p_hold) else $error("holding byte wrong");

	property p_short_drop;
		@(posedge i_clk) disable iff (!i_resetn)
		(state == DNL_ST_SHIFT && !frame_active) |=> !word_stb;
	endproperty
	a_short_drop: assert property (p_short_drop) else $error("short frame gave a word");

	property p_done_ignore;
		@(posedge i_clk) disable iff (!i_resetn)
		state == DNL_ST_DONE |=> $stable(shift) && !word_stb;
	endproperty
	a_done_ignore: assert property (p_done_ignore) else $error("bits taken after word");

	property p_amp_zero;
		@(posedge i_clk) disable iff (!i_resetn)
		o_phase == {PH_W{1'b0}} |=> o_amplitude == `DNL_AMP_MID;
	endproperty
	a_amp_zero: assert property (p_amp_zero) else $error("zero phase not mid-scale");

	property p_src_write;
		@(posedge i_clk) disable iff (!i_resetn)
		(ctl_sel && !i_clear_input) |=> src_bit == $past(word[`DNL_CTL_SRC_BIT]);
	endproperty
	a_src_write: assert property (p_src_write) else $error("source bit not written");

	property p_fbit_write;
		@(posedge i_clk) disable iff (!i_resetn)
		(word_stb && !is_ctl && cmd == DNL_CMD_FSEL && !i_clear_input) |=>
			fbit == $past(word[`DNL_CTL_FREQ_BIT]);
	endproperty
	a_fbit_write: assert property (p_fbit_write) else $error("frequency bit not written");

	property p_pbits_write;
		@(posedge i_clk) disable iff (!i_resetn)
		(word_stb && !is_ctl && cmd == DNL_CMD_PSEL && !i_clear_input) |=>
			pbits == $past({word[`DNL_CTL_PHI_BIT], word[`DNL_CTL_PLO_BIT]});
	endproperty
	a_pbits_write: assert property (p_pbits_write) else $error("phase bits not written");

	property p_pin_phase;
		@(posedge i_clk) disable iff (!i_resetn)
		1'b1 |=> ppin == $past({i_phase_choice_hi, i_phase_choice_lo});
	endproperty
	a_pin_phase: assert property (p_pin_phase) else $error("phase pins not sampled");
endmodule
`default_nettype wire

// ==== bench/dnl_host_model.sv ====
// Host side serial writer model for the oscillator loader
`default_nettype none
module dnl_host_model (
	// Master clock for pacing
	input wire logic i_clk,
	// Serial write lines
	output logic o_sclk,
	output logic o_serial_data_in,
	output logic o_frame_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle lines
	initial begin
		o_sclk = 1'b0;
		o_serial_data_in = 1'b0;
		o_frame_n = 1'b1;
	end
	// Wait n master clocks, moving only on falling edges
	task automatic gap(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Send nb bits of w; park 0 low, 1 high, 2 free running
	task automatic send(input logic [15:0] w, input logic [1:0] park, input int nb);
		gap(1);
		o_frame_n = 1'b0;
		gap(2);
		for (int i = 15; i > 15 - nb; i--) begin
			o_serial_data_in = w[i];
			o_sclk = 1'b1;
			gap(3);
			o_sclk = 1'b0;
			gap(3);
		end
		o_frame_n = 1'b1;
		o_serial_data_in = ~o_serial_data_in; // Released line does not keep last bit
		o_sclk = park[0];
		gap(3);
		if (park == 2'h2) begin
			repeat (2) begin
				o_sclk = 1'b1;
				gap(3);
				o_sclk = 1'b0;
				gap(3);
			end
		end
	endtask
endmodule
`default_nettype wire

// ==== bench/dnl_core_tb.sv ====
// Self-checking bench for the oscillator serial loader
`default_nettype none
module dnl_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic clr = 1'b0;
	logic fch = 1'b0;
	logic plo = 1'b0;
	logic phi = 1'b0;
	wire sclk;
	wire serial_data_in;
	wire frame_n;
	logic [9:0] amp;
	logic [11:0] ph;
	logic src;
	int miscompares = 0;
	int check_count = 0;
	// Master clock, 20 ns period
	always #10 clk = ~clk;
	dnl_host_model host (.i_clk(clk), .o_sclk(sclk), .o_serial_data_in(serial_data_in), .o_frame_n(frame_n));
	dnl_core DUT (.i_clk(clk), .i_resetn(resetn), .i_clear_input(clr), .i_sclk(sclk),
		.i_serial_data_in(serial_data_in), .i_word_frame_n(frame_n), .i_frequency_choice(fch),
		.i_phase_choice_lo(plo), .i_phase_choice_hi(phi), .o_amplitude(amp),
		.o_phase(ph), .o_choice_source_bit(src));
	// Compare and count
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Phase advance over n clocks once the pipeline has settled
	task automatic step_of(input int n, output logic [11:0] d);
		logic [11:0] a;
		host.gap(4);
		a = ph;
		repeat (n) @(negedge clk);
		d = ph - a;
	endtask
	// Phase change over ten clocks across a choice change
	task automatic jump(input logic f, input logic hi, input logic lo, output logic [11:0] d);
		logic [11:0] a;
		host.gap(4);
		a = ph;
		fch = f;
		phi = hi;
		plo = lo;
		repeat (10) @(negedge clk);
		d = ph - a;
	endtask
	// Outputs after reset
	task automatic t_reset();
		chk("amplitude", 12'h200, {2'h0, amp});
		chk("phase", 12'h000, ph);
		chk("source", 12'h000, {11'h000, src});
	endtask
	// Amplitude at zero and quarter phase, frequency still zero
	task automatic t_amp();
		host.send(16'h1e00, 2'h0, 16);
		host.send(16'h0f04, 2'h0, 16);
		chk("amp zero", 12'h200, {2'h0, amp});
		phi = 1'b1;
		plo = 1'b1;
		host.gap(4);
		chk("quarter phase", 12'h400, ph);
		chk("amp quarter", 12'h3ff, {2'h0, amp});
		phi = 1'b0;
		plo = 1'b0;
		host.gap(4);
	endtask
	// Frequency word 0 high half, parked low clock
	task automatic t_freq0();
		logic [11:0] d;
		host.send(16'h3230, 2'h0, 16);
		step_of(2, d);
		chk("hold only", 12'h000, d);
		host.send(16'h2300, 2'h0, 16);
		step_of(4, d);
		chk("step f0", 12'h00c, d);
	endtask
	// Frequency word 1 by pin, parked high clock
	task automatic t_fsel();
		logic [11:0] d;
		host.send(16'h3650, 2'h1, 16);
		host.send(16'h2700, 2'h1, 16);
		jump(1'b1, 1'b0, 1'b0, d);
		chk("continuity", 12'h001, {11'h000, (d >= 12'h01e) && (d <= 12'h032)});
		step_of(4, d);
		chk("step f1", 12'h014, d);
	endtask
	// Phase offset 2 with free running clock
	task automatic t_offset();
		logic [11:0] d;
		host.send(16'h1c23, 2'h2, 16);
		host.send(16'h0d01, 2'h2, 16);
		fch = 1'b0;
		jump(1'b0, 1'b1, 1'b0, d);
		chk("offset2", 12'h141, d);
		jump(1'b0, 1'b0, 1'b1, d);
		chk("offset1", 12'hefb, d);
		plo = 1'b0;
	endtask
	// Control word, register choices and clear
	task automatic t_ctrl();
		logic [11:0] d;
		logic [11:0] a;
		host.send(16'ha000, 2'h0, 10);
		chk("short frame", 12'h000, {11'h000, src});
		host.send(16'ha000, 2'h0, 16);
		chk("source set", 12'h001, {11'h000, src});
		host.send(16'h5800, 2'h0, 16);
		step_of(4, d);
		chk("bit f1", 12'h014, d);
		host.send(16'h6400, 2'h0, 16);
		step_of(4, d);
		chk("bits f0", 12'h00c, d);
		// Offset bits to 3 across one word: 102 steps of 3 plus offset change
		a = ph;
		host.send(16'h4600, 2'h0, 16);
		d = ph - a;
		chk("bits p3", 12'h40f, d);
		// Clear raised while offset 3 is chosen by bits
		host.gap(4);
		a = ph;
		clr = 1'b1;
		repeat (10) @(negedge clk);
		d = ph - a;
		chk("clear", 12'hc1e, d);
		chk("source clr", 12'h000, {11'h000, src});
		clr = 1'b0;
	endtask
	// Verdict and end of run
	task automatic summarize();
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		t_reset();
		t_amp();
		t_freq0();
		t_fsel();
		t_offset();
		t_ctrl();
		summarize();
	end
	// Watchdog
	initial begin
		#200us;
		miscompares++;
		summarize();
	end
endmodule
`default_nettype wire
